// ==== core/tcr_ctrl.sv ====
// Controller that reads thermal calibration data from the processor over JTAG.
// Assumes the processor sits in its power-up wait state when start arrives.
// Operation
// (RULE1) Controller issues ordered test-port commands for data
// (RULE2) Device waits in power-up state for scan
// (RULE3) Device unusable afterwards; controller requests restart
// (RULE4) Read once; keep values in storage
// (RULE5) Cold temperature bits 39:46, minus 40; code reads 7 bits 39:45
// (RULE6) Hot temperature bits 32:38, unadjusted
// (RULE7) Cold voltage bits 20:31, half plus 300
// (RULE8) Hot voltage bits 8:19, half plus 300
// (RULE9) Reverse every field before adjusting
// (RULE10) Temperatures in degrees, voltages in millivolts
// (RULE11) Two points give linear voltage-temperature map
// (RULE12) Alarm asserted on unsafe measured temperature
// (RULE13) Alarm active low, high otherwise
// (RULE14) Device I2C address is 1000 plus index
// (RULE15) Processor index is a 3-bit strap
// (RULE16) One-cycle valid after all 64 bits
// (RULE17) Counter and valid cleared on reset, new readout
`timescale 1ns/10ps
`default_nettype none
module tcr_ctrl #(
  parameter int READ_BITS = tcr_pkg::READ_BITS,
  parameter int IR_LEN    = tcr_pkg::IR_LEN
) (
  input  wire logic        clk,               // 100 MHz system clock
  input  wire logic        rst,               // Synchronous reset
  input  wire logic        start,             // Begin one readout
  input  wire logic [1:0]  modifier_sel,      // Scan ring modifier choice
  input  wire logic [2:0]  processor_index,   // Strapped index of target
  input  wire logic        tdo,               // Test data from device
  input  wire logic [11:0] diode_mv,          // Measured diode voltage
  input  wire logic        diode_mv_valid,    // Measurement strobe
  input  wire logic [7:0]  alarm_limit,       // Alarm threshold, degrees C
  output logic             tck,               // Test clock
  output logic             tms,               // Test mode select
  output logic             tdi,               // Test data to device
  output logic             trst_n,            // Test-port reset
  output logic             busy,              // Readout in progress
  output logic             result_valid,      // One-cycle results ready
  output logic signed [8:0] temp_low,         // Cold point, degrees C
  output logic       [7:0] temp_high,         // Hot point, degrees C
  output logic      [11:0] volt_low,          // Cold point, mV
  output logic      [11:0] volt_high,         // Hot point, mV
  output logic             cal_stored,        // Values held
  output logic             restart_req,       // Device needs restart
  output logic      [6:0]  i2c_addr,          // Device I2C address
  output logic signed [9:0] die_temp,         // Mapped die temperature
  output logic             thermal_alarm_n    // Thermal alarm, low active
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RESET, ST_IR, ST_MOD, ST_DR, ST_DONE
  } tcr_state_type;

  // TDO synchroniser
  logic tdo_s1_reg, tdo_s2_reg;
  always_ff @(posedge clk) begin
    tdo_s1_reg <= tdo;
    tdo_s2_reg <= tdo_s1_reg;
  end

  // Test clock divider: rise and fall enables
  logic [7:0] div_reg, div_next;
  logic       tck_reg, tck_next;
  logic       fall_en, rise_en;
  always_comb begin
    div_next = div_reg + 8'h01;
    tck_next = tck_reg;
    fall_en  = 1'b0;
    rise_en  = 1'b0;
    if (div_reg == 8'(tcr_pkg::TCK_DIV - 1)) begin
      div_next = 8'h00;
      tck_next = ~tck_reg;
      fall_en  = tck_reg;
      rise_en  = ~tck_reg;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 8'h00;
      tck_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tck_reg <= tck_next;
    end
  end

  // Sequencer: reset, instruction, modifier, data shift
  tcr_state_type st_reg, st_next;
  logic [7:0]    cnt_reg, cnt_next;
  logic [63:0]   sh_reg, sh_next;
  logic [31:0]   mod_reg, mod_next;
  logic          tms_reg, tms_next, tdi_reg, tdi_next;
  logic          trst_reg, trst_next, done_reg, done_next;
  logic          stored_reg, stored_next, rst_req_reg, rst_req_next;
  logic          busy_next, pending_reg, pending_next;

  function automatic logic [31:0] pick_mod(input logic [1:0] s);
    case (s)
      2'd1:    pick_mod = tcr_pkg::MODIFIER_B;
      2'd2:    pick_mod = tcr_pkg::MODIFIER_C;
      default: pick_mod = tcr_pkg::MODIFIER_A;
    endcase
  endfunction : pick_mod

  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    sh_next      = sh_reg;
    mod_next     = mod_reg;
    tms_next     = tms_reg;
    tdi_next     = tdi_reg;
    trst_next    = 1'b1;
    done_next    = 1'b0;
    stored_next  = stored_reg;
    rst_req_next = rst_req_reg;
    pending_next = pending_reg | start;
    case (st_reg)
      ST_IDLE: begin
        if (pending_reg && !stored_reg && fall_en) begin      // RULE4
          pending_next = 1'b0;
          mod_next     = pick_mod(modifier_sel);               // RULE2
          cnt_next     = 8'h00;                                // RULE17
          trst_next    = 1'b0;
          tms_next     = 1'b1;
          st_next      = ST_RESET;
        end else if (stored_reg) begin
          pending_next = 1'b0;
        end
      end
      ST_RESET: if (fall_en) begin                             // RULE1
        cnt_next = cnt_reg + 8'h01;
        tms_next = (cnt_reg < 8'd5) || (cnt_reg == 8'd6) || (cnt_reg == 8'd7);
        if (cnt_reg == 8'd9) begin
          cnt_next = 8'h00;
          tms_next = 1'b0;
          st_next  = ST_IR;
        end
      end
      ST_IR: if (fall_en) begin
        tdi_next = tcr_pkg::SCAN_INSTR[cnt_reg[2:0]];
        tms_next = (cnt_reg == 8'(IR_LEN - 1));
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(IR_LEN)) begin
          tms_next = 1'b1;
          cnt_next = 8'h00;
          st_next  = ST_MOD;
        end
      end
      ST_MOD: if (fall_en) begin
        tdi_next = mod_reg[cnt_reg[4:0]];
        tms_next = (cnt_reg == 8'd31);
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'd32) begin
          tms_next = 1'b0;
          cnt_next = 8'h00;
          st_next  = ST_DR;
        end
      end
      ST_DR: begin
        // First rise enters Capture-DR, second leaves it; bits stand from the third rise on
        if (rise_en && cnt_reg >= 8'd2 && cnt_reg <= 8'(READ_BITS + 1))
          sh_next = {tdo_s2_reg, sh_reg[63:1]};
        if (fall_en) begin
          tdi_next = 1'b0;
          tms_next = (cnt_reg == 8'(READ_BITS));
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == 8'(READ_BITS + 1)) begin
            tms_next = 1'b1;
            st_next  = ST_DONE;
          end
        end
      end
      ST_DONE: if (fall_en) begin
        done_next    = 1'b1;                                   // RULE16
        stored_next  = 1'b1;                                   // RULE4
        rst_req_next = 1'b1;                                   // RULE3
        st_next      = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
    busy_next = (st_next != ST_IDLE);
  end

  logic busy_reg;
  always_ff @(posedge clk) begin
    if (rst) begin                                             // RULE17
      st_reg      <= ST_IDLE;
      cnt_reg     <= 8'h00;
      sh_reg      <= '0;
      mod_reg     <= tcr_pkg::MODIFIER_A;
      tms_reg     <= 1'b1;
      tdi_reg     <= 1'b0;
      trst_reg    <= 1'b0;
      done_reg    <= 1'b0;
      stored_reg  <= 1'b0;
      rst_req_reg <= 1'b0;
      pending_reg <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      sh_reg      <= sh_next;
      mod_reg     <= mod_next;
      tms_reg     <= tms_next;
      tdi_reg     <= tdi_next;
      trst_reg    <= trst_next;
      done_reg    <= done_next;
      stored_reg  <= stored_next;
      rst_req_reg <= rst_req_next;
      pending_reg <= pending_next;
      busy_reg    <= busy_next;
    end
  end

  tcr_decode u_decode (
    .clk       (clk),
    .rst       (rst),
    .raw       (sh_reg),
    .valid_in  (done_reg),
    .temp_low  (temp_low),
    .temp_high (temp_high),
    .volt_low  (volt_low),
    .volt_high (volt_high),
    .valid_out (result_valid)
  );

  // Linear map from diode voltage to temperature, and alarm
  logic signed [9:0] dt_reg, dt_next;
  logic              alarm_n_reg, alarm_n_next;
  logic [6:0]        addr_reg, addr_next;
  logic signed [31:0] num, den, q;
  always_comb begin
    num = ($signed({20'h0_0000, diode_mv}) - $signed({20'h0_0000, volt_low}))
          * ($signed({24'h00_0000, temp_high}) - 32'(temp_low));            // RULE11
    den = $signed({20'h0_0000, volt_high}) - $signed({20'h0_0000, volt_low});
    q   = (den == 32'sd0) ? 32'sd0 : num / den;
    dt_next = dt_reg;
    if (diode_mv_valid && stored_reg)
      dt_next = 10'(q + 32'(temp_low));
    alarm_n_next = !(stored_reg && dt_reg > $signed({2'b00, alarm_limit})); // RULE12 RULE13
    addr_next    = {tcr_pkg::I2C_ADDR_UPPER, processor_index};             // RULE14 RULE15
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dt_reg      <= '0;
      alarm_n_reg <= 1'b1;
      addr_reg    <= {tcr_pkg::I2C_ADDR_UPPER, tcr_pkg::PROC_INDEX_RESET};
    end else begin
      dt_reg      <= dt_next;
      alarm_n_reg <= alarm_n_next;
      addr_reg    <= addr_next;
    end
  end

  assign tck             = tck_reg;
  assign tms             = tms_reg;
  assign tdi             = tdi_reg;
  assign trst_n          = trst_reg;
  assign busy            = busy_reg;
  assign cal_stored      = stored_reg;
  assign restart_req     = rst_req_reg;
  assign die_temp        = dt_reg;
  assign thermal_alarm_n = alarm_n_reg;
  assign i2c_addr        = addr_reg;
endmodule : tcr_ctrl
`default_nettype wire

// ==== core/tcr_pkg.sv ====
// Package for the thermal calibration readout controller.
// Assumes a 100 MHz system clock and a sampled JTAG link to the processor.
package tcr_pkg;
  localparam int TCK_DIV         = 4;     // System cycles per half test clock
  localparam int READ_BITS       = 64;
  localparam int IR_LEN          = 8;
  localparam int TEMP_LOW_POS    = 39;
  localparam int TEMP_HIGH_POS   = 32;
  localparam int VOLT_LOW_POS    = 20;
  localparam int VOLT_HIGH_POS   = 8;
  localparam int TEMP_BITS       = 7;
  localparam int VOLT_BITS       = 12;
  localparam int TEMP_LOW_OFFSET = 40;
  localparam int VOLT_OFFSET     = 300;
  localparam logic [31:0] MODIFIER_A = 32'h00C0_8000;
  localparam logic [31:0] MODIFIER_B = 32'h00C0_4000;
  localparam logic [31:0] MODIFIER_C = 32'h0080_4001;
  localparam logic [3:0]  I2C_ADDR_UPPER = 4'h8;
  localparam logic [2:0]  PROC_INDEX_RESET = 3'h0;
  localparam logic [7:0]  SCAN_INSTR = 8'h00;  // Arbitrary scan-ring select instruction
  typedef enum logic [1:0] {
    TCR_MOD_A,
    TCR_MOD_B,
    TCR_MOD_C
  } tcr_mod_type;
endpackage : tcr_pkg

// ==== core/tcr_decode.sv ====
// Decoder of the first 64-bit calibration read into degrees and millivolts.
// Assumes the raw word is stable while valid_in is high.
`timescale 1ns/10ps
`default_nettype none
module tcr_decode (
  input  wire logic        clk,            // System clock
  input  wire logic        rst,            // Synchronous reset
  input  wire logic [63:0] raw,            // First 64-bit read
  input  wire logic        valid_in,       // Raw word complete
  output logic signed [8:0] temp_low,      // Cold point, degrees C
  output logic       [7:0] temp_high,      // Hot point, degrees C
  output logic      [11:0] volt_low,       // Cold point, mV
  output logic      [11:0] volt_high,      // Hot point, mV
  output logic             valid_out       // One-cycle result pulse
);
  function automatic logic [6:0] rev7(input logic [6:0] v);
    for (int i = 0; i < 7; i++) rev7[i] = v[6-i];
  endfunction : rev7
  function automatic logic [11:0] rev12(input logic [11:0] v);
    for (int i = 0; i < 12; i++) rev12[i] = v[11-i];
  endfunction : rev12
  function automatic logic [11:0] volt_adj(input logic [11:0] v);
    volt_adj = 12'({1'b0, v[11:1]} + 12'(tcr_pkg::VOLT_OFFSET));  // RULE7 RULE8 RULE10
  endfunction : volt_adj

  logic signed [8:0] tl_next;
  logic [7:0]        th_next;
  logic [11:0]       vl_next;
  logic [11:0]       vh_next;
  logic              v_next;
  always_comb begin
    tl_next = 9'($signed({2'b00, rev7(raw[tcr_pkg::TEMP_LOW_POS +: tcr_pkg::TEMP_BITS])}))
              - 9'(tcr_pkg::TEMP_LOW_OFFSET);                                   // RULE5 RULE9
    th_next = {1'b0, rev7(raw[tcr_pkg::TEMP_HIGH_POS +: tcr_pkg::TEMP_BITS])}; // RULE6 RULE9
    vl_next = volt_adj(rev12(raw[tcr_pkg::VOLT_LOW_POS +: tcr_pkg::VOLT_BITS]));  // RULE9
    vh_next = volt_adj(rev12(raw[tcr_pkg::VOLT_HIGH_POS +: tcr_pkg::VOLT_BITS])); // RULE9
    v_next  = valid_in;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_low  <= '0;
      temp_high <= '0;
      volt_low  <= '0;
      volt_high <= '0;
      valid_out <= 1'b0;
    end else begin
      valid_out <= v_next;
      if (valid_in) begin
        temp_low  <= tl_next;
        temp_high <= th_next;
        volt_low  <= vl_next;
        volt_high <= vh_next;
      end
    end
  end
endmodule : tcr_decode
`default_nettype wire

// ==== tb/tcr_jtag_dev.sv ====
// Behavioural test port of the processor holding the calibration fuses.
// Assumes tck comes from the controller and keeps running between scans.
`timescale 1ns/10ps
`default_nettype none
module tcr_jtag_dev (
  input  wire logic        tck,     // Test clock
  input  wire logic        tms,     // Mode select
  input  wire logic        tdi,     // Data in
  input  wire logic        trst_n,  // Port reset
  input  wire logic [63:0] word,    // First ring read
  output var  logic        tdo      // Data out
);
  localparam logic [63:0] NEXT_ONE  = 64'hF977_89DD_417F_0155;
  localparam logic [63:0] NEXT_ZERO = 64'hCACC_BABA_62CE_3232;
  logic [3:0]  st;
  logic [63:0] sh;
  initial tdo = 1'b0;
  always @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st <= 4'hF;
    end else begin
      if (st == 4'h6) begin
        sh <= word;
      end else if (st == 4'h2) begin
        sh <= {tdi, sh[63:1]};
      end
      st <= tms ? NEXT_ONE[st*4 +: 4] : NEXT_ZERO[st*4 +: 4];
    end
  end
  // Outside a data scan the line shows no stale bit
  always @(negedge tck) tdo <= (st == 4'h2) ? sh[0] : ~tdo;
endmodule : tcr_jtag_dev
`default_nettype wire

// ==== tb/tcr_ctrl_assertions.sv ====
// Port checker for the calibration readout controller.
// Assumes one clock domain with synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module tcr_ctrl_checker #(
  parameter int READ_BITS = 64,
  parameter int IR_LEN    = 8
) (
  input wire logic              clk,              // Clock
  input wire logic              rst,              // Reset
  input wire logic              start,            // Request
  input wire logic [2:0]        processor_index,  // Strap
  input wire logic [7:0]        alarm_limit,      // Threshold
  input wire logic              tck,              // Test clock
  input wire logic              busy,             // Busy
  input wire logic              result_valid,     // Result pulse
  input wire logic              cal_stored,       // Stored
  input wire logic              restart_req,      // Restart
  input wire logic [6:0]        i2c_addr,         // Address
  input wire logic signed [9:0] die_temp,         // Die temp
  input wire logic              thermal_alarm_n   // Alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  addr_map_a: assert property ($stable(processor_index) && !$past(rst) |-> i2c_addr == {4'h8, processor_index})
    else $error("Address not formed from index");
  valid_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("Result valid too long");
  valid_idle_a: assert property (result_valid |-> !busy)
    else $error("Result valid while busy");
  valid_done_a: assert property ($fell(busy) |-> ##[0:3] result_valid)
    else $error("No result after readout");
  store_soon_a: assert property (result_valid |-> ##[0:2] (cal_stored && restart_req))
    else $error("Values not stored");
  store_hold_a: assert property (cal_stored && restart_req |=> cal_stored && restart_req)
    else $error("Stored flags dropped");
  once_only_a: assert property ($rose(busy) |-> !$past(cal_stored))
    else $error("Second readout started");
  tck_half_a: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("Test clock high phase wrong");
  alarm_map_a: assert property ((cal_stored && !die_temp[9] && $stable(die_temp) && $stable(alarm_limit)) [*4]
    |-> thermal_alarm_n == !(die_temp > $signed({2'b00, alarm_limit}))) else $error("Alarm level wrong");
  alarm_idle_a: assert property (!cal_stored |-> thermal_alarm_n)
    else $error("Alarm before calibration");
  cover property (result_valid);
  cover property (!thermal_alarm_n);
  cover property (start && cal_stored);
endmodule : tcr_ctrl_checker
bind tcr_ctrl tcr_ctrl_checker #(.READ_BITS(READ_BITS), .IR_LEN(IR_LEN)) u_chk (.clk, .rst, .start,
  .processor_index, .alarm_limit, .tck, .busy, .result_valid, .cal_stored, .restart_req, .i2c_addr,
  .die_temp, .thermal_alarm_n);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the calibration readout controller.
// Assumes the processor model answers on the test port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic              clk, rst, start, tdo, diode_mv_valid, tck, tms, tdi, trst_n;
  logic              busy, result_valid, cal_stored, restart_req, thermal_alarm_n;
  logic [1:0]        modifier_sel;
  logic [2:0]        processor_index;
  logic [11:0]       diode_mv, volt_low, volt_high, exp_vl, exp_vh;
  logic [7:0]        alarm_limit, temp_high, exp_th;
  logic signed [8:0] temp_low;
  logic signed [9:0] die_temp;
  logic [8:0]        exp_tl;
  logic [6:0]        i2c_addr;
  logic [63:0]       word;
  int                n_mismatch = 0;
  int                samples_checked = 0;
  tcr_ctrl u_dut (.clk, .rst, .start, .modifier_sel, .processor_index, .tdo, .diode_mv, .diode_mv_valid,
    .alarm_limit, .tck, .tms, .tdi, .trst_n, .busy, .result_valid, .temp_low, .temp_high, .volt_low,
    .volt_high, .cal_stored, .restart_req, .i2c_addr, .die_temp, .thermal_alarm_n);
  tcr_jtag_dev u_dev (.tck, .tms, .tdi, .trst_n, .word, .tdo);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic do_reset(input logic [2:0] idx);
    rst = 1'b1;
    processor_index = idx;
    repeat (5) @(negedge clk);
    chk("reset_pins", 32'h0000_000C, 32'({busy, result_valid, tck, tms, thermal_alarm_n, cal_stored, restart_req}));
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("i2c_addr", 32'({4'h8, idx}), 32'(i2c_addr));
  endtask : do_reset
  task automatic readout(input int k, input logic [1:0] sel, input logic [2:0] idx, input bit abort);
    logic [6:0]  tl;
    logic [6:0]  th;
    logic [11:0] vl;
    logic [11:0] vh;
    int          i;
    tl = 7'(25 + k * 30);
    th = 7'(100 + k);
    vl = 12'(1001 + k * 2);
    vh = 12'(601 + k * 100);
    word = 64'hA5C3_5A3C_0F0F_F0F0 ^ 64'(k);
    for (i = 0; i < 12; i++) begin
      if (i < 7) word[39 + i] = tl[6 - i];
      if (i < 7) word[32 + i] = th[6 - i];
      word[20 + i] = vl[11 - i];
      word[8 + i] = vh[11 - i];
    end
    exp_tl = {2'b00, tl} - 9'h028;
    exp_th = {1'b0, th};
    exp_vl = (vl >> 1) + 12'h12C;
    exp_vh = (vh >> 1) + 12'h12C;
    do_reset(idx);
    modifier_sel = sel;
    pulse(start);
    if (abort) begin
      repeat (300) @(negedge clk);
      chk("busy", 32'h0000_0001, 32'(busy));
      do_reset(idx);
      pulse(start);
    end
    for (i = 0; i < 3000 && result_valid !== 1'b1; i++) @(negedge clk);
    if (i == 3000) begin
      n_mismatch++;
      give_verdict();
    end
    chk("temp_low", 32'(exp_tl), 32'({temp_low}));
    chk("temp_high", 32'(exp_th), 32'(temp_high));
    chk("volt_low", 32'(exp_vl), 32'(volt_low));
    chk("volt_high", 32'(exp_vh), 32'(volt_high));
    @(negedge clk);
    chk("result_valid", 32'h0000_0000, 32'(result_valid));
    repeat (2) @(negedge clk);
    chk("stored_restart", 32'h0000_0003, 32'({cal_stored, restart_req}));
  endtask : readout
  task automatic refuse_check;
    logic seen;
    seen = 1'b0;
    pulse(start);
    repeat (200) begin
      seen |= busy | result_valid;
      @(negedge clk);
    end
    chk("second_readout", 32'h0000_0000, 32'(seen));
  endtask : refuse_check
  task automatic alarm_check;
    diode_mv = exp_vh;
    alarm_limit = 8'h63;
    pulse(diode_mv_valid);
    repeat (6) @(negedge clk);
    chk("die_temp", 32'({2'b00, exp_th}), 32'({die_temp}));
    chk("alarm_n", 32'h0000_0000, 32'(thermal_alarm_n));
    alarm_limit = 8'h64;
    repeat (4) @(negedge clk);
    chk("alarm_n", 32'h0000_0001, 32'(thermal_alarm_n));
    alarm_limit = 8'hFF;
    diode_mv = exp_vl;
    pulse(diode_mv_valid);
    repeat (6) @(negedge clk);
    chk("die_temp", 32'({exp_tl[8], exp_tl}), 32'({die_temp}));
  endtask : alarm_check
  initial begin
    rst = 1'b1;
    start = 1'b0;
    modifier_sel = 2'h0;
    processor_index = 3'h0;
    diode_mv = 12'h000;
    diode_mv_valid = 1'b0;
    alarm_limit = 8'hFF;
    word = 64'h0000_0000_0000_0000;
    readout(0, 2'h0, 3'h0, 1'b0);
    refuse_check();
    alarm_check();
    readout(1, 2'h1, 3'h5, 1'b1);
    readout(2, 2'h2, 3'h7, 1'b0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
